// ==== design/data_move_defines.svh ====
// register offsets, field positions, reset values and clock counts of the decoder
`ifndef DATA_MOVE_DEFINES_SVH
`define DATA_MOVE_DEFINES_SVH

`define OFS_CTRL          8'h00
`define OFS_INSTR         8'h04
`define OFS_OPERAND       8'h08
`define OFS_STATUS        8'h0c

`define CTRL_PROT_BIT     0
`define CTRL_CPL_LSB      1
`define CTRL_PORT_PRIVILEGE_THRESHOLD_LSB     3
`define CTRL_RESET        5'h00

`define INSTR_OPC_LSB     0
`define INSTR_MODRM_LSB   8
`define OPND_OFS_LSB      0
`define OPND_LIMIT_BIT    16
`define OPND_ACCESS_BIT   17
`define OPND_STACK_BIT    18

`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_EXC_BIT        2
`define ST_CLASS_LSB      3
`define ST_VEC_LSB        8
`define ST_CLK_LSB        16
`define ST_WORD_BIT       21
`define ST_LOCK_BIT       22
`define ST_ILLEGAL_BIT    23
`define ST_REG_LSB        24
`define ST_IMM_LSB        27
`define ST_SEXT_BIT       29
`define ST_VARPORT_BIT    30

`define VEC_GP            8'h0d
`define VEC_STACK         8'h0c
`define WORD_TOP_OFS      16'hffff

`define CLK_SEG_LOAD_R    5'h02
`define CLK_SEG_LOAD_RM   5'h05
`define CLK_SEG_LOAD_P    5'h11
`define CLK_SEG_LOAD_PM   5'h13
`define CLK_SEG_STORE     5'h02
`define CLK_SEG_STORE_M   5'h03
`define CLK_PUSH_MEM      5'h05
`define CLK_PUSH          5'h03
`define CLK_PUSH_ALL      5'h11
`define CLK_POP           5'h05
`define CLK_POP_SEG_P     5'h14
`define CLK_POP_ALL       5'h13
`define CLK_SWAP          5'h03
`define CLK_SWAP_M        5'h05
`define CLK_IN            5'h05
`define CLK_OUT           5'h03
`define CLK_TRANSLATE     5'h05

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ==== design/data_move_pkg.sv ====
// types shared by the data-move decoder
package data_move_pkg;

    typedef enum logic [4:0] {
        CL_NONE             = 5'h00,
        CL_SEG_LOAD         = 5'h01,
        CL_SEG_STORE        = 5'h02,
        CL_PUSH_MEM         = 5'h03,
        CL_PUSH_REG         = 5'h04,
        CL_PUSH_SEG         = 5'h05,
        CL_PUSH_IMM         = 5'h06,
        CL_PUSH_ALL_REGS    = 5'h07,
        CL_POP_MEM          = 5'h08,
        CL_POP_REG          = 5'h09,
        CL_POP_SEG          = 5'h0a,
        CL_POP_ALL_REGS     = 5'h0b,
        CL_SWAP_OPERANDS_RM = 5'h0c,
        CL_SWAP_OPERANDS_AC = 5'h0d,
        CL_IN_FIXED         = 5'h0e,
        CL_IN_VAR           = 5'h0f,
        CL_OUT_FIXED        = 5'h10,
        CL_OUT_VAR          = 5'h11,
        CL_TABLE_TRANSLATE  = 5'h12
    } op_class_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_t;

    typedef struct packed {
        op_class_t  cls;
        logic [4:0] clocks;
        logic       word;
        logic       mem;
        logic [2:0] reg_sel;
        logic [1:0] imm_bytes;
        logic       sext;
        logic       var_port;
        logic       lock;
        logic       illegal;
        logic       note_overrun;
        logic       note_prot;
        logic       io;
    } decode_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_state_t;

    typedef struct packed {
        axi_state_t  axi;
        logic [4:0]  ctrl;
        logic [15:0] instr;
        logic [18:0] operand;
        decode_t     dec;
        exec_state_t st;
        logic [4:0]  count;
        logic        busy;
        logic        done;
        logic        exc;
        logic [7:0]  exc_vec;
        logic        lock;
        logic        exc_pulse;
        logic        done_pulse;
    } core_state_t;

endpackage : data_move_pkg

// ==== design/data_move_decode.sv ====
// decode and timing of the data-move, stack, swap, port and translate instructions
//
// Overview of operation
// - 8e modrm loads segment; 2/5 real, 17/19 protected
// - 8c modrm stores segment; 2/3 clocks
// - ff with reg field 110 pushes memory, 5
// - 01010 reg pushes general register, 3 clocks
// - 000 sel 110 pushes segment register, 3 clocks
// - 011010s0 pushes immediate, s picks bytes, 3
// - 60 pushes all registers in 17 clocks
// - 8f with reg field 000 pops memory, 5
// - 01011 reg pops general register, 5 clocks
// - 000 sel 111 pops segment, not sel 01
// - 61 pops all registers in 19 clocks
// - swap with register 3, with memory 5
// - 10010 reg swaps with accumulator, 3 clocks
// - 1110010w with port byte reads port, 5
// - 1110110w reads register-addressed port, 5 clocks
// - 1110011w with port byte writes port, 3
// - 1110111w writes register-addressed port, 3 clocks
// - d7 translates low accumulator byte, 5 clocks
// - memory swap drives bus lock while it runs, not when it faults
// - protected port access above threshold raises 13
// - real word operand at ffff raises 13
// - protected limit/access violation 13, stack 12
`timescale 1ns/1ps
`include "data_move_defines.svh"

module data_move_decode
    import data_move_pkg::*;
(
    input  wire logic        MCLK,          // processor clock, 40 MHz
    input  wire logic        RESET,         // synchronous, active high
    input  wire logic [7:0]  S_AXI_AWADDR,  // write address
    input  wire logic        S_AXI_AWVALID, // write address valid
    output logic             S_AXI_AWREADY, // write address ready
    input  wire logic [31:0] S_AXI_WDATA,   // write data
    input  wire logic [3:0]  S_AXI_WSTRB,   // write byte strobes
    input  wire logic        S_AXI_WVALID,  // write data valid
    output logic             S_AXI_WREADY,  // write data ready
    output logic [1:0]       S_AXI_BRESP,   // write response
    output logic             S_AXI_BVALID,  // write response valid
    input  wire logic        S_AXI_BREADY,  // write response ready
    input  wire logic [7:0]  S_AXI_ARADDR,  // read address
    input  wire logic        S_AXI_ARVALID, // read address valid
    output logic             S_AXI_ARREADY, // read address ready
    output logic [31:0]      S_AXI_RDATA,   // read data
    output logic [1:0]       S_AXI_RRESP,   // read response
    output logic             S_AXI_RVALID,  // read data valid
    input  wire logic        S_AXI_RREADY,  // read data ready
    output logic             BUSY,          // instruction executing
    output logic             BUS_LOCK,      // exclusive bus lock
    output logic             EXC_PULSE,     // one-cycle exception event
    output logic [7:0]       EXC_VECTOR,    // exception vector of the last started instruction, else 0
    output logic             DONE_PULSE     // one-cycle completion event
);

    core_state_t cur_ff;
    core_state_t nxt_ff;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic decode_t decode(input logic [7:0] opc,
                                       input logic [7:0] modrm,
                                       input logic       prot);
        decode_t d;
        logic    is_mem;
        is_mem         = (modrm[7:6] != 2'h3);
        d              = '0;
        d.cls          = CL_NONE;
        d.word         = 1'b1;
        d.note_overrun = 1'b1;
        d.note_prot    = 1'b1;
        casez (opc)
            8'b1000_1110: begin
                d.cls     = CL_SEG_LOAD;
                d.mem     = is_mem;
                d.reg_sel = modrm[5:3];
                if (prot) begin
                    d.clocks = is_mem ? `CLK_SEG_LOAD_PM : `CLK_SEG_LOAD_P;
                end else begin
                    d.clocks = is_mem ? `CLK_SEG_LOAD_RM : `CLK_SEG_LOAD_R;
                end
            end
            8'b1000_1100: begin
                d.cls     = CL_SEG_STORE;
                d.mem     = is_mem;
                d.reg_sel = modrm[5:3];
                d.clocks  = is_mem ? `CLK_SEG_STORE_M : `CLK_SEG_STORE;
            end
            8'b1111_1111: begin
                d.cls     = CL_PUSH_MEM;
                d.mem     = 1'b1;
                d.clocks  = `CLK_PUSH_MEM;
                d.illegal = (modrm[5:3] != 3'h6);
            end
            8'b0101_0???: begin
                d.cls     = CL_PUSH_REG;
                d.reg_sel = opc[2:0];
                d.clocks  = `CLK_PUSH;
            end
            8'b0101_1???: begin
                d.cls     = CL_POP_REG;
                d.reg_sel = opc[2:0];
                d.clocks  = `CLK_POP;
            end
            8'b000?_?110: begin
                d.cls     = CL_PUSH_SEG;
                d.reg_sel = {1'b0, opc[4:3]};
                d.clocks  = `CLK_PUSH;
            end
            8'b000?_?111: begin
                d.cls     = CL_POP_SEG;
                d.reg_sel = {1'b0, opc[4:3]};
                d.illegal = (opc[4:3] == 2'h1);
                d.clocks  = prot ? `CLK_POP_SEG_P : `CLK_POP;
            end
            8'b0110_10?0: begin
                d.cls       = CL_PUSH_IMM;
                d.sext      = opc[1];
                d.imm_bytes = opc[1] ? 2'h1 : 2'h2;
                d.clocks    = `CLK_PUSH;
            end
            8'b0110_0000: begin
                d.cls    = CL_PUSH_ALL_REGS;
                d.clocks = `CLK_PUSH_ALL;
            end
            8'b0110_0001: begin
                d.cls    = CL_POP_ALL_REGS;
                d.clocks = `CLK_POP_ALL;
            end
            8'b1000_1111: begin
                d.cls     = CL_POP_MEM;
                d.mem     = 1'b1;
                d.clocks  = `CLK_POP;
                d.illegal = (modrm[5:3] != 3'h0);
            end
            8'b1000_011?: begin
                d.cls     = CL_SWAP_OPERANDS_RM;
                d.word    = opc[0];
                d.mem     = is_mem;
                d.reg_sel = modrm[5:3];
                d.clocks  = is_mem ? `CLK_SWAP_M : `CLK_SWAP;
                d.lock    = is_mem;
            end
            8'b1001_0???: begin
                d.cls          = CL_SWAP_OPERANDS_AC;
                d.reg_sel      = opc[2:0];
                d.clocks       = `CLK_SWAP;
                d.note_overrun = 1'b0;
                d.note_prot    = 1'b0;
            end
            8'b1110_?1??: begin
                d.word         = opc[0];
                d.io           = 1'b1;
                d.note_overrun = 1'b0;
                d.note_prot    = 1'b0;
                d.var_port     = opc[3];
                d.imm_bytes    = opc[3] ? 2'h0 : 2'h1;
                d.illegal      = opc[4];
                if (opc[1]) begin
                    d.cls    = opc[3] ? CL_OUT_VAR : CL_OUT_FIXED;
                    d.clocks = `CLK_OUT;
                end else begin
                    d.cls    = opc[3] ? CL_IN_VAR : CL_IN_FIXED;
                    d.clocks = `CLK_IN;
                end
            end
            8'b1101_0111: begin
                d.cls          = CL_TABLE_TRANSLATE;
                d.word         = 1'b0;
                d.mem          = 1'b1;
                d.clocks       = `CLK_TRANSLATE;
                d.note_overrun = 1'b0;
            end
            default: begin
                d.illegal = 1'b1;
            end
        endcase
        return d;
    endfunction : decode

    // exception check: returns {raised, vector}
    function automatic logic [8:0] check_exc(input decode_t     d,
                                             input logic [4:0]  ctrl,
                                             input logic [18:0] opnd);
        logic       prot;
        logic [1:0] current_privilege_level;
        logic [1:0] port_privilege_threshold;
        logic [8:0] res;
        prot = ctrl[`CTRL_PROT_BIT];
        current_privilege_level  = ctrl[`CTRL_CPL_LSB +: 2];
        port_privilege_threshold = ctrl[`CTRL_PORT_PRIVILEGE_THRESHOLD_LSB +: 2];
        res  = 9'h000;
        if (prot && d.io && (current_privilege_level > port_privilege_threshold)) begin
            res = {1'b1, `VEC_GP};
        end else if (prot && d.note_prot && opnd[`OPND_STACK_BIT]) begin
            res = {1'b1, `VEC_STACK};
        end else if (prot && d.note_prot
                     && (opnd[`OPND_LIMIT_BIT] || opnd[`OPND_ACCESS_BIT])) begin
            res = {1'b1, `VEC_GP};
        end else if (!prot && d.note_overrun && d.word
                     && (opnd[`OPND_OFS_LSB +: 16] == `WORD_TOP_OFS)) begin
            res = {1'b1, `VEC_GP};
        end
        return res;
    endfunction : check_exc

    logic        wr_fire;
    logic        start;
    logic        done_clr;
    logic [31:0] status_word;
    logic [31:0] new_word;
    logic [8:0]  exc_chk;
    decode_t     dec_new;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.exc_pulse  = 1'b0;
        nxt_ff.done_pulse = 1'b0;

        status_word = 32'h0000_0000;
        status_word[`ST_BUSY_BIT]          = cur_ff.busy;
        status_word[`ST_DONE_BIT]          = cur_ff.done;
        status_word[`ST_EXC_BIT]           = cur_ff.exc;
        status_word[`ST_CLASS_LSB +: 5]    = cur_ff.dec.cls;
        status_word[`ST_VEC_LSB +: 8]      = cur_ff.exc_vec;
        status_word[`ST_CLK_LSB +: 5]      = cur_ff.dec.clocks;
        status_word[`ST_WORD_BIT]          = cur_ff.dec.word;
        status_word[`ST_LOCK_BIT]          = cur_ff.dec.lock;
        status_word[`ST_ILLEGAL_BIT]       = cur_ff.dec.illegal;
        status_word[`ST_REG_LSB +: 3]      = cur_ff.dec.reg_sel;
        status_word[`ST_IMM_LSB +: 2]      = cur_ff.dec.imm_bytes;
        status_word[`ST_SEXT_BIT]          = cur_ff.dec.sext;
        status_word[`ST_VARPORT_BIT]       = cur_ff.dec.var_port;

        // write channels are taken independently, the write happens once both are held
        if (S_AXI_AWVALID && cur_ff.axi.awready) begin
            nxt_ff.axi.aw_held = 1'b1;
            nxt_ff.axi.awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && cur_ff.axi.wready) begin
            nxt_ff.axi.w_held = 1'b1;
            nxt_ff.axi.wdata  = S_AXI_WDATA;
            nxt_ff.axi.wstrb  = S_AXI_WSTRB;
        end
        wr_fire  = cur_ff.axi.aw_held && cur_ff.axi.w_held && !cur_ff.axi.bvalid;
        start    = 1'b0;
        done_clr = 1'b0;
        new_word = 32'h0000_0000;
        if (wr_fire) begin
            nxt_ff.axi.aw_held = 1'b0;
            nxt_ff.axi.w_held  = 1'b0;
            nxt_ff.axi.bvalid  = 1'b1;
            nxt_ff.axi.bresp   = `RESP_OKAY;
            unique case (cur_ff.axi.awaddr)
                `OFS_CTRL: begin
                    new_word    = merge_bytes({27'h0, cur_ff.ctrl}, cur_ff.axi.wdata,
                                              cur_ff.axi.wstrb);
                    nxt_ff.ctrl = new_word[4:0];
                end
                `OFS_INSTR: begin
                    new_word     = merge_bytes({16'h0, cur_ff.instr}, cur_ff.axi.wdata,
                                               cur_ff.axi.wstrb);
                    // a new instruction while one runs is ignored
                    if (!cur_ff.busy) begin
                        nxt_ff.instr = new_word[15:0];
                        start        = 1'b1;
                    end
                end
                `OFS_OPERAND: begin
                    new_word       = merge_bytes({13'h0, cur_ff.operand}, cur_ff.axi.wdata,
                                                 cur_ff.axi.wstrb);
                    nxt_ff.operand = new_word[18:0];
                end
                `OFS_STATUS: begin
                    done_clr = cur_ff.axi.wstrb[0] && cur_ff.axi.wdata[`ST_DONE_BIT];
                end
                default: begin
                    nxt_ff.axi.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (cur_ff.axi.bvalid && S_AXI_BREADY) begin
            nxt_ff.axi.bvalid = 1'b0;
        end
        nxt_ff.axi.awready = !nxt_ff.axi.aw_held && !nxt_ff.axi.bvalid;
        nxt_ff.axi.wready  = !nxt_ff.axi.w_held && !nxt_ff.axi.bvalid;

        if (S_AXI_ARVALID && cur_ff.axi.arready) begin
            nxt_ff.axi.rvalid = 1'b1;
            nxt_ff.axi.rresp  = `RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `OFS_CTRL:    nxt_ff.axi.rdata = {27'h0, cur_ff.ctrl};
                `OFS_INSTR:   nxt_ff.axi.rdata = {16'h0, cur_ff.instr};
                `OFS_OPERAND: nxt_ff.axi.rdata = {13'h0, cur_ff.operand};
                `OFS_STATUS:  nxt_ff.axi.rdata = status_word;
                default: begin
                    nxt_ff.axi.rdata = 32'h0000_0000;
                    nxt_ff.axi.rresp = `RESP_SLVERR;
                end
            endcase
        end else if (cur_ff.axi.rvalid && S_AXI_RREADY) begin
            nxt_ff.axi.rvalid = 1'b0;
        end
        nxt_ff.axi.arready = !nxt_ff.axi.rvalid;

        dec_new = decode(new_word[`INSTR_OPC_LSB +: 8], new_word[`INSTR_MODRM_LSB +: 8],
                         cur_ff.ctrl[`CTRL_PROT_BIT]);
        exc_chk = check_exc(dec_new, cur_ff.ctrl, cur_ff.operand);

        if (done_clr) begin
            nxt_ff.done = 1'b0;
        end
        unique case (cur_ff.st)
            ST_IDLE: begin
                if (start) begin
                    nxt_ff.dec     = dec_new;
                    nxt_ff.exc     = 1'b0;
                    nxt_ff.exc_vec = 8'h00;
                    nxt_ff.done    = 1'b0;
                    if (dec_new.illegal) begin
                        nxt_ff.done       = 1'b1;
                        nxt_ff.done_pulse = 1'b1;
                    end else if (exc_chk[8]) begin
                        // a faulting instruction never executes
                        nxt_ff.exc        = 1'b1;
                        nxt_ff.exc_vec    = exc_chk[7:0];
                        nxt_ff.exc_pulse  = 1'b1;
                        nxt_ff.done       = 1'b1;
                        nxt_ff.done_pulse = 1'b1;
                    end else begin
                        nxt_ff.st    = ST_EXEC;
                        nxt_ff.busy  = 1'b1;
                        nxt_ff.count = dec_new.clocks - 5'h01;
                        nxt_ff.lock  = dec_new.lock;
                    end
                end
            end
            ST_EXEC: begin
                if (cur_ff.count == 5'h00) begin
                    nxt_ff.st         = ST_IDLE;
                    nxt_ff.busy       = 1'b0;
                    nxt_ff.lock       = 1'b0;
                    nxt_ff.done       = 1'b1;
                    nxt_ff.done_pulse = 1'b1;
                end else begin
                    nxt_ff.count = cur_ff.count - 5'h01;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cur_ff             <= '0;
            cur_ff.axi.awready <= 1'b1;
            cur_ff.axi.wready  <= 1'b1;
            cur_ff.axi.arready <= 1'b1;
            cur_ff.ctrl        <= `CTRL_RESET;
            cur_ff.dec.cls     <= CL_NONE;
            cur_ff.st          <= ST_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign S_AXI_AWREADY = cur_ff.axi.awready;
    assign S_AXI_WREADY  = cur_ff.axi.wready;
    assign S_AXI_BRESP   = cur_ff.axi.bresp;
    assign S_AXI_BVALID  = cur_ff.axi.bvalid;
    assign S_AXI_ARREADY = cur_ff.axi.arready;
    assign S_AXI_RDATA   = cur_ff.axi.rdata;
    assign S_AXI_RRESP   = cur_ff.axi.rresp;
    assign S_AXI_RVALID  = cur_ff.axi.rvalid;
    assign BUSY          = cur_ff.busy;
    assign BUS_LOCK      = cur_ff.lock;
    assign EXC_PULSE     = cur_ff.exc_pulse;
    assign EXC_VECTOR    = cur_ff.exc_vec;
    assign DONE_PULSE    = cur_ff.done_pulse;

endmodule : data_move_decode

// ==== verif/data_move_decode_monitor.sv ====
// checker on the decoder's run and event outputs
`timescale 1ns/1ps
module data_move_monitor (
    input wire logic       MCLK,       // clock
    input wire logic       RESET,      // reset
    input wire logic       BUSY,       // running
    input wire logic       BUS_LOCK,   // lock
    input wire logic       EXC_PULSE,  // fault
    input wire logic [7:0] EXC_VECTOR, // vector
    input wire logic       DONE_PULSE  // done
);
    logic [4:0] run_ff;
    always_ff @(posedge MCLK) run_ff <= (RESET || !BUSY) ? 5'h00 : run_ff + 5'h01;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    property p_lk; BUS_LOCK |-> BUSY; endproperty
    a_lk: assert property (p_lk) else $error("lock while idle");
    property p_lkh; BUSY && $past(BUSY) |-> BUS_LOCK == $past(BUS_LOCK); endproperty
    a_lkh: assert property (p_lkh) else $error("lock dropped in run");
    property p_ex; EXC_PULSE |-> DONE_PULSE && !BUSY; endproperty
    a_ex: assert property (p_ex) else $error("fault without end");
    property p_vec; EXC_PULSE |-> ##[0:1] EXC_VECTOR inside {8'h0c, 8'h0d}; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_dn; DONE_PULSE |=> !DONE_PULSE; endproperty
    a_dn: assert property (p_dn) else $error("done too long");
    property p_end; $fell(BUSY) |-> DONE_PULSE; endproperty
    a_end: assert property (p_end) else $error("run ended silently");
    property p_len; $fell(BUSY) |-> run_ff inside {5'h02, 5'h03, 5'h05, 5'h11, 5'h13, 5'h14};
    endproperty
    a_len: assert property (p_len) else $error("bad run length");
    property p_cap; BUSY |-> run_ff < 5'h14; endproperty
    a_cap: assert property (p_cap) else $error("run too long");
    c_lk: cover property (BUS_LOCK);
    c_ex: cover property (EXC_PULSE);
    c_long: cover property ($fell(BUSY) && run_ff == 5'h14);
endmodule : data_move_monitor

bind data_move_decode data_move_monitor data_move_monitor_inst (.MCLK, .RESET, .BUSY,
    .BUS_LOCK, .EXC_PULSE, .EXC_VECTOR, .DONE_PULSE);

// ==== verif/data_move_decode_test.sv ====
// bench for the decoder: register traffic and timed instruction runs
`timescale 1ns/1ps
module data_move_decode_test;
    logic        mclk = '0, reset = '1, awv = '0, wv = '0, brdy = '0, arv = '0, rrdy = '0;
    logic [7:0]  awa = '0, ara = '0, vec;
    logic [31:0] wd = '0, rd;
    logic        awr, wrr, bv, arr, rv, busy, lock, excp, donep;
    logic [1:0]  rr, br;
    int          err_total = 0, compares = 0, busy_n, lock_n, exc_n, done_n;
    // ctrl, operand code, modrm+opcode, lock bit with clock count, fault vector
    logic [43:0] cases [$] = '{
        44'h000c0870300, 44'h000c08e0200, 44'h000068e0500, 44'h010c08e1100, 44'h010068e1300,
        44'h000c08c0200, 44'h000068c0300, 44'h00036ff0500, 44'h00006ff0000, 44'h00000530300,
        44'h000001e0300, 44'h00000680300, 44'h010006a0300, 44'h00000601100, 44'h000068f0500,
        44'h0000e8f0000, 44'h000005b0500, 44'h000001f0500, 44'h010001f1400, 44'h000000f0000,
        44'h00000611300, 44'h00000930300, 44'h01000e40500, 44'h01000ec0500, 44'h01000e60300,
        44'h00000ef0300, 44'h00000d70500, 44'h07000e4000d, 44'h1f000ee0300, 44'h0080087000d,
        44'h00800868500, 44'h0140053000c, 44'h011068e000d};
    data_move_decode data_move_decode_inst (.MCLK(mclk), .RESET(reset), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
        .BUSY(busy), .BUS_LOCK(lock), .EXC_PULSE(excp), .EXC_VECTOR(vec), .DONE_PULSE(donep));
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) {busy_n, lock_n, exc_n, done_n} = {busy_n + int'(busy === 1'h1),
        lock_n + int'(lock === 1'h1), exc_n + int'(excp === 1'h1), done_n + int'(donep === 1'h1)};
    task automatic chk(input string nm, input logic [31:0] e, s);
        compares++;
        err_total += int'(s !== e);
        if (s !== e) $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    endtask : chk
    // one write or one read, held until the response handshake
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {awa, ara, wd} <= {a, a, d};
        {awv, wv, brdy, arv, rrdy} <= {w, w, w, !w, !w};
        do begin
            @(posedge mclk);
            if (awr) awv <= 1'h0;
            if (wrr) wv <= 1'h0;
            if (arr) arv <= 1'h0;
        end while ((w ? bv : rv) !== 1'h1);
        {brdy, rrdy} <= 2'h0;
    endtask : bus
    task automatic ex(input logic [43:0] t);
        bus(1'h1, 8'h00, {24'h0, t[43:36]});
        bus(1'h1, 8'h08, {13'h0, t[34:32], {16{t[35]}}});
        {busy_n, lock_n, exc_n, done_n} = '0;
        bus(1'h1, 8'h04, {16'h0, t[31:16]});
        chk("instr write resp", 32'h0, {30'h0, br});
        while (done_n == 0) @(posedge mclk);
        chk("clocks", {27'h0, t[12:8]}, busy_n);
        chk("lock", t[15] ? {27'h0, t[12:8]} : 32'h0, lock_n);
        chk("fault", {31'h0, t[7:0] != 8'h0}, exc_n);
        if (t[7:0] != 8'h0) chk("vector", {24'h0, t[7:0]}, {24'h0, vec});
        $display("test %h ended", t[31:16]);
    endtask : ex
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        repeat (9000) @(posedge mclk);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'h0;
        bus(1'h0, 8'h00, 32'h0);
        chk("ctrl", 32'h0, rd);
        bus(1'h0, 8'h40, 32'h0);
        chk("unmapped", 32'h2, {rd[31:2], rr});
        bus(1'h1, 8'h40, 32'h0);
        chk("unmapped write", 32'h2, {30'h0, br});
        ex(44'h00000878500);
        bus(1'h0, 8'h0c, 32'h0);
        chk("status", 32'h00650062, rd);
        bus(1'h1, 8'h0c, 32'h2);
        chk("status write resp", 32'h0, {30'h0, br});
        bus(1'h0, 8'h0c, 32'h0);
        chk("done cleared", 32'h00650060, rd);
        foreach (cases[n]) ex(cases[n]);
        complete_run();
    end
endmodule : data_move_decode_test
